// file: csi_top.sv
// Codec serial interface: Wishbone registers, shadows and serial engine
// How it works
// - Enabled block owns the bit clock, data out and frame sync pin directions
// - Clock direction bit: drive own clock or receive
// - Data out pin is output, driven when sending
// - Idle data out tristated or low, by bit
// - Data in pin is input only
// - Frame sync pin direction follows its bit
// - Engine works on shadow copies of buffers
// - Words are stored left justified
// - Short received words get zero low bits
// - Short transmit words drop unused low bits
// - Word length programmable up to sixteen
// - Up to sixteen slots, 256 bit frame
// - Four words buffered per direction
// - Multi-channel, I2S and AC-Link modes
// - 16-bit shifter, MSB first
// - Disable resets counters, stops clocks
// - Length field holds length minus one
// - Sync master when direction bit clear
`timescale 1ns/100ps
`default_nettype none
module csi_top (
   // System
   input wire logic i_clk,
   input wire logic i_rst,
   // Wishbone slave
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   // Link pins
   input wire logic i_serial_bit_clock_pin,
   input wire logic i_serial_in_pin,
   input wire logic i_frame_sync_pin,
   output var csi_pkg::csi_pin_type o_serial_bit_clock_pin,
   output var csi_pkg::csi_pin_type o_serial_out_pin,
   output var csi_pkg::csi_pin_type o_frame_sync_pin
);
   import csi_pkg::*;

   logic [31:0] ctrl1; // Enable, directions, mode, divider
   logic [31:0] ctrl2; // Word and frame length
   logic [15:0] slot_en; // Active slot mask
   logic [15:0] tx_reg [CSI_WORDS]; // CPU side transmit words
   logic [15:0] rx_reg [CSI_WORDS]; // CPU side receive words
   logic [15:0] tx_sh [CSI_WORDS]; // Engine side transmit copy
   logic [15:0] rx_sh [CSI_WORDS]; // Engine side receive copy
   logic rx_full, tx_empty, ovr; // Sticky status
   logic [2:0] s1, s2; // Pin synchronisers {fs, in, clk}
   logic ck_prev, fs_prev; // Edge history
   logic [11:0] div_cnt; // Bit clock generator count
   logic gclk; // Generated bit clock
   csi_state_type state;
   logic [3:0] bit_cnt, slot_cnt; // Position within frame
   logic [1:0] addr; // Shared buffer address
   logic [1:0] rx_idx; // Drain position into receive copy
   logic go; // Slave frame start pending
   logic [15:0] tx_shift, rx_shift; // Shift registers
   logic tx_bit, tx_on, fs_m; // Engine pin levels
   logic rx_push; // Received word pulse
   logic [15:0] rx_word; // Left justified received word
   logic f_ready, d_valid; // Buffer handshakes
   logic [15:0] d_data;
   // Decoded controls
   logic en, ckdir, idle_low, fsdir, rise_t, fall_t, gen_tog, start_ok, act;
   logic [11:0] div;
   logic [3:0] wlen, flen, next_bit, next_slot;
   csi_mode_type mode;
   logic wr, rd_req, service, last_bit, load_msb, next_fs;
   logic [31:0] rdata;

   // Byte lane merge for register writes
   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
      for (int i = 0; i < 4; i++) begin
         if (s[i]) o[8*i +: 8] = n[8*i +: 8];
      end
      return o;
   endfunction

   assign en = ctrl1[CSI_EN_BIT];
   assign ckdir = ctrl1[CSI_CKDIR_BIT];
   assign idle_low = ctrl1[CSI_IDLE_BIT];
   assign fsdir = ctrl1[CSI_FSDIR_BIT];
   assign mode = csi_mode_type'(ctrl1[CSI_MODE_LSB +: 2]);
   assign div = ctrl1[CSI_DIV_LSB +: 12];
   // AC-Link fixes the slot and frame sizes; field is length minus one
   assign wlen = mode[1] ? CSI_AC_WLEN : ctrl2[CSI_WL_LSB +: 4];
   assign flen = mode[1] ? CSI_AC_FLEN : ctrl2[CSI_FL_LSB +: 4];
   assign wr = i_wb_cyc & i_wb_stb & i_wb_we & o_wb_ack;
   assign rd_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;

   // Wishbone ack, one wait state, dropped the cycle after
   always_ff @(posedge i_clk) begin
      if (i_rst) o_wb_ack <= 1'b0;
      else o_wb_ack <= i_wb_cyc & i_wb_stb & ~o_wb_ack;
   end

   // Read mux; unmapped offsets read zero
   always_comb begin
      rdata = '0;
      case (i_wb_adr[7:4])
         CSI_PAGE_TX: rdata = {16'h0000, tx_reg[i_wb_adr[3:2]]};
         CSI_PAGE_RX: rdata = {16'h0000, rx_reg[i_wb_adr[3:2]]};
         default: begin
            case (i_wb_adr)
               CSI_OFS_CTRL1: rdata = ctrl1;
               CSI_OFS_CTRL2: rdata = ctrl2;
               CSI_OFS_SLOTS: rdata = {16'h0000, slot_en};
               CSI_OFS_STATUS: begin
                  rdata[CSI_RXFULL_BIT] = rx_full;
                  rdata[CSI_TXEMPTY_BIT] = tx_empty;
                  rdata[CSI_OVR_BIT] = ovr;
                  rdata[CSI_ADDR_LSB +: 2] = addr;
                  rdata[CSI_STATE_LSB +: 2] = state;
               end
               default: rdata = '0;
            endcase
         end
      endcase
   end

   // Read data captured while the request waits for ack
   always_ff @(posedge i_clk) begin
      if (i_rst) o_wb_dat <= '0;
      else if (rd_req) o_wb_dat <= rdata;
   end

   // Control registers, written on the ack edge
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ctrl1 <= CSI_CTRL1_RST;
         ctrl2 <= CSI_CTRL2_RST;
         slot_en <= CSI_SLOTS_RST;
      end else if (wr) begin
         case (i_wb_adr)
            CSI_OFS_CTRL1: ctrl1 <= merge(ctrl1, i_wb_dat, i_wb_sel);
            CSI_OFS_CTRL2: ctrl2 <= merge(ctrl2, i_wb_dat, i_wb_sel) & 32'h0000_00FF;
            CSI_OFS_SLOTS: slot_en <= 16'(merge({16'h0000, slot_en}, i_wb_dat, i_wb_sel));
            default: ;
         endcase
      end
   end

   // CPU transmit words; engine never touches these
   always_ff @(posedge i_clk) begin
      if (wr && i_wb_adr[7:4] == CSI_PAGE_TX) begin
         tx_reg[i_wb_adr[3:2]] <= 16'(merge({16'h0000, tx_reg[i_wb_adr[3:2]]}, i_wb_dat,
                                           i_wb_sel));
      end
   end

   // Two flops on every link input; only the second is read
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s1 <= '0;
         s2 <= '0;
      end else begin
         s1 <= {i_frame_sync_pin, i_serial_in_pin, i_serial_bit_clock_pin};
         s2 <= s1;
      end
   end

   // Bit clock generator: half period of div+1 system clocks
   assign gen_tog = en && div != '0 && div_cnt == div;
   always_ff @(posedge i_clk) begin
      if (i_rst || !en || div == '0) begin
         div_cnt <= '0;
         gclk <= 1'b0;
      end else if (div_cnt == div) begin
         div_cnt <= '0;
         gclk <= ~gclk;
      end else div_cnt <= div_cnt + 12'h001;
   end

   // Bit clock edges from the chosen source
   always_ff @(posedge i_clk) begin
      if (i_rst) ck_prev <= 1'b0;
      else ck_prev <= s2[0];
   end
   assign rise_t = ckdir ? (s2[0] & ~ck_prev) : (gen_tog & ~gclk);
   assign fall_t = ckdir ? (~s2[0] & ck_prev) : (gen_tog & gclk);

   // Next frame position and master sync level
   assign last_bit = (bit_cnt == wlen);
   assign start_ok = ~fsdir | go;
   always_comb begin
      next_bit = bit_cnt + 4'h1;
      next_slot = slot_cnt;
      if (state != CSI_ST_RUN || last_bit) begin
         next_bit = '0;
         next_slot = (state != CSI_ST_RUN || slot_cnt == flen) ? 4'h0 : slot_cnt + 4'h1;
      end
      case (mode)
         CSI_MULTI: next_fs = (next_bit == wlen) && (next_slot == flen);
         CSI_I2S: next_fs = (next_slot <= (flen >> 1));
         default: next_fs = (next_slot == 4'h0);
      endcase
   end
   assign act = slot_en[next_slot];
   assign load_msb = tx_sh[addr][15];
   assign service = rise_t && state == CSI_ST_RUN && last_bit && slot_en[slot_cnt]
                    && addr == 2'(CSI_WORDS - 1);

   // Frame sequencing on falling bit clock edges
   always_ff @(posedge i_clk) begin
      if (i_rst || !en) begin
         state <= CSI_ST_IDLE;
         bit_cnt <= '0;
         slot_cnt <= '0;
         tx_on <= 1'b0;
         tx_bit <= 1'b0;
         fs_m <= 1'b0;
         tx_shift <= '0;
      end else if (state == CSI_ST_IDLE) begin
         state <= CSI_ST_ARMED;
      end else if (fall_t) begin
         if (state == CSI_ST_RUN && !(last_bit && slot_cnt == flen)) begin
            bit_cnt <= next_bit;
            slot_cnt <= next_slot;
         end else if (start_ok) begin
            state <= CSI_ST_RUN;
            bit_cnt <= '0;
            slot_cnt <= '0;
         end else begin
            state <= CSI_ST_ARMED; // Slave waits for the next sync
         end
         fs_m <= next_fs;
         if (next_bit == '0) begin
            tx_on <= act && (state == CSI_ST_RUN ? !(last_bit && slot_cnt == flen) || start_ok
                                                 : start_ok);
            tx_shift <= tx_sh[addr];
            tx_bit <= load_msb;
         end else begin
            tx_shift <= tx_shift << 1;
            tx_bit <= tx_shift[14];
         end
      end
   end

   // Sampling, slave sync detection and buffer address on rising edges
   always_ff @(posedge i_clk) begin
      if (i_rst || !en) begin
         rx_shift <= '0;
         rx_push <= 1'b0;
         rx_word <= '0;
         addr <= '0;
         go <= 1'b0;
         fs_prev <= 1'b0;
      end else begin
         rx_push <= 1'b0;
         if (fall_t) go <= 1'b0;
         if (rise_t) begin
            fs_prev <= s2[2];
            // Slave takes sync only while armed or in the last bit of a frame
            if (fsdir && (state == CSI_ST_ARMED || (last_bit && slot_cnt == flen))
                && (mode == CSI_I2S ? s2[2] != fs_prev : s2[2])) go <= 1'b1;
            if (state == CSI_ST_RUN) begin
               rx_shift <= {rx_shift[14:0], s2[1]};
               if (last_bit && slot_en[slot_cnt]) begin
                  rx_word <= {rx_shift[14:0], s2[1]} << (CSI_MAX_WLEN - wlen);
                  rx_push <= 1'b1;
                  addr <= addr + 2'h1;
               end
            end
         end
      end
   end

   // Transmit copy refreshed after the fourth word goes out
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         for (int i = 0; i < CSI_WORDS; i++) tx_sh[i] <= '0;
      end else if (service) begin
         for (int i = 0; i < CSI_WORDS; i++) tx_sh[i] <= tx_reg[i];
      end
   end

   // Receive words wait here if software is slow to collect
   csi_pair_fifo #(.W(CSI_DW), .DEPTH(2)) u_rx_buf (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_flush(~en),
      .i_valid(rx_push),
      .i_data(rx_word),
      .o_ready(f_ready),
      .o_valid(d_valid),
      .o_data(d_data),
      .i_ready(~rx_full)
   );

   // Drain into the receive copy; publish after four words
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         rx_idx <= '0;
         // Software sees zeros, not junk, before the first batch lands
         for (int i = 0; i < CSI_WORDS; i++) rx_reg[i] <= '0;
      end else if (!en) begin
         rx_idx <= '0;
      end else if (d_valid && !rx_full) begin
         rx_sh[rx_idx] <= d_data;
         rx_idx <= rx_idx + 2'h1;
         if (rx_idx == 2'(CSI_WORDS - 1)) begin
            for (int i = 0; i < CSI_WORDS - 1; i++) rx_reg[i] <= rx_sh[i];
            rx_reg[CSI_WORDS - 1] <= d_data;
         end
      end
   end

   // Sticky status; a new event beats a same-cycle write-one clear
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         rx_full <= 1'b0;
         tx_empty <= 1'b0;
         ovr <= 1'b0;
      end else begin
         if (d_valid && !rx_full && rx_idx == 2'(CSI_WORDS - 1)) rx_full <= 1'b1;
         else if (wr && i_wb_adr == CSI_OFS_STATUS && i_wb_sel[0]
                  && i_wb_dat[CSI_RXFULL_BIT]) rx_full <= 1'b0;
         if (service) tx_empty <= 1'b1;
         else if (wr && i_wb_adr == CSI_OFS_STATUS && i_wb_sel[0]
                  && i_wb_dat[CSI_TXEMPTY_BIT]) tx_empty <= 1'b0;
         if (rx_push && !f_ready) ovr <= 1'b1;
         else if (wr && i_wb_adr == CSI_OFS_STATUS && i_wb_sel[0]
                  && i_wb_dat[CSI_OVR_BIT]) ovr <= 1'b0;
      end
   end

   // Pin drivers; all released while disabled
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_serial_bit_clock_pin <= '{drive: 1'b0, oe_n: 1'b1};
         o_serial_out_pin <= '{drive: 1'b0, oe_n: 1'b1};
         o_frame_sync_pin <= '{drive: 1'b0, oe_n: 1'b1};
      end else begin
         o_serial_bit_clock_pin <= '{drive: gclk, oe_n: ~(en & ~ckdir)};
         o_serial_out_pin <= '{drive: tx_bit & tx_on,
                               oe_n: ~(en & (tx_on | idle_low))};
         o_frame_sync_pin <= '{drive: fs_m & ~fsdir, oe_n: ~(en & ~fsdir)};
      end
   end

   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   property p_release;
      !en |=> (o_serial_bit_clock_pin.oe_n && o_serial_out_pin.oe_n && o_frame_sync_pin.oe_n);
   endproperty
   a_release: assert property (p_release) else $error("pins not released");
   property p_ckdir;
      en |=> (o_serial_bit_clock_pin.oe_n == $past(ckdir));
   endproperty
   a_ckdir: assert property (p_ckdir) else $error("bit clock direction wrong");
   property p_drive;
      (en && tx_on) |=> !o_serial_out_pin.oe_n && o_serial_out_pin.drive == $past(tx_bit);
   endproperty
   a_drive: assert property (p_drive) else $error("data out not driven");
   property p_idle;
      (en && !tx_on) |=> (o_serial_out_pin.oe_n == !$past(idle_low)) && !o_serial_out_pin.drive;
   endproperty
   a_idle: assert property (p_idle) else $error("idle data out wrong");
   property p_fsdir;
      en |=> (o_frame_sync_pin.oe_n == $past(fsdir));
   endproperty
   a_fsdir: assert property (p_fsdir) else $error("frame sync direction wrong");
   property p_stop;
      !en |=> (state == CSI_ST_IDLE && addr == 2'h0 && bit_cnt == 4'h0 && !gclk);
   endproperty
   a_stop: assert property (p_stop) else $error("disable left counters running");
   property p_zero;
      rx_push |-> (rx_word & ((16'h0001 << (CSI_MAX_WLEN - wlen)) - 16'h0001)) == 16'h0000;
   endproperty
   a_zero: assert property (p_zero) else $error("receive low bits not zero");
   property p_bounds;
      state == CSI_ST_RUN |-> (bit_cnt <= wlen && slot_cnt <= flen);
   endproperty
   a_bounds: assert property (p_bounds) else $error("frame position out of range");
   property p_shadow;
      service |=> (tx_sh[0] == $past(tx_reg[0]) && tx_sh[3] == $past(tx_reg[3]));
   endproperty
   a_shadow: assert property (p_shadow) else $error("transmit copy not refreshed");
   property p_msb;
      (en && fall_t && state == CSI_ST_RUN && next_bit == 4'h0) |=> tx_bit == $past(load_msb);
   endproperty
   a_msb: assert property (p_msb) else $error("first bit is not the MSB");
endmodule // csi_top
`default_nettype wire

// file: csi_pkg.sv
// Shared constants and types for the codec serial interface
package csi_pkg;
   // Register byte offsets
   localparam logic [7:0] CSI_OFS_CTRL1 = 8'h00;
   localparam logic [7:0] CSI_OFS_CTRL2 = 8'h04;
   localparam logic [7:0] CSI_OFS_SLOTS = 8'h08;
   localparam logic [7:0] CSI_OFS_STATUS = 8'h0C;
   localparam logic [3:0] CSI_PAGE_TX = 4'h1;
   localparam logic [3:0] CSI_PAGE_RX = 4'h2;
   // Control one fields
   localparam int CSI_EN_BIT = 0;
   localparam int CSI_CKDIR_BIT = 1;
   localparam int CSI_IDLE_BIT = 2;
   localparam int CSI_FSDIR_BIT = 3;
   localparam int CSI_MODE_LSB = 4;
   localparam int CSI_DIV_LSB = 16;
   // Control two fields
   localparam int CSI_WL_LSB = 0;
   localparam int CSI_FL_LSB = 4;
   // Status fields
   localparam int CSI_RXFULL_BIT = 0;
   localparam int CSI_TXEMPTY_BIT = 1;
   localparam int CSI_OVR_BIT = 2;
   localparam int CSI_ADDR_LSB = 4;
   localparam int CSI_STATE_LSB = 8;
   // Reset values
   localparam logic [31:0] CSI_CTRL1_RST = 32'h0000_0000;
   localparam logic [31:0] CSI_CTRL2_RST = 32'h0000_00FF;
   localparam logic [15:0] CSI_SLOTS_RST = 16'h000F;
   // Data and framing sizes
   localparam int CSI_DW = 16;
   localparam int CSI_WORDS = 4;
   localparam logic [3:0] CSI_AC_WLEN = 4'hF;
   localparam logic [3:0] CSI_AC_FLEN = 4'hF;
   localparam logic [3:0] CSI_MAX_WLEN = 4'hF;
   // Frame sync modes
   typedef enum logic [1:0] {
      CSI_MULTI = 2'b00,
      CSI_I2S = 2'b01,
      CSI_AC16 = 2'b10,
      CSI_AC20 = 2'b11
   } csi_mode_type;
   // Serial engine states
   typedef enum logic [1:0] {
      CSI_ST_IDLE = 2'b00,
      CSI_ST_ARMED = 2'b01,
      CSI_ST_RUN = 2'b10
   } csi_state_type;
   // One two-way pin seen from inside: level driven and low-active enable
   typedef struct packed {
      logic drive;
      logic oe_n;
   } csi_pin_type;
endpackage

// file: csi_pair_fifo.sv
// Small valid/ready buffer between the serial engine and the receive shadow
`timescale 1ns/100ps
`default_nettype none
module csi_pair_fifo #(
   parameter int W = 16,
   parameter int DEPTH = 2
) (
   // System
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_flush,
   // Fill side
   input wire logic i_valid,
   input wire logic [W-1:0] i_data,
   output logic o_ready,
   // Drain side
   output logic o_valid,
   output logic [W-1:0] o_data,
   input wire logic i_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [W-1:0] mem [DEPTH]; // Storage
   logic [AW-1:0] wp; // Write pointer
   logic [AW-1:0] rp; // Read pointer
   logic [AW:0] cnt; // Entries held
   logic push;
   logic pop;

   // Pointer step with wrap for any depth
   function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
   endfunction

   assign o_ready = (cnt != (AW + 1)'(DEPTH));
   assign o_valid = (cnt != '0);
   assign o_data = mem[rp];
   assign push = i_valid & o_ready;
   assign pop = o_valid & i_ready;

   // Pointers and count; flush drops held words
   always_ff @(posedge i_clk) begin
      if (i_rst || i_flush) begin
         wp <= '0;
         rp <= '0;
         cnt <= '0;
      end else begin
         if (push) wp <= inc(wp);
         if (pop) rp <= inc(rp);
         if (push && !pop) cnt <= cnt + (AW + 1)'(1);
         else if (pop && !push) cnt <= cnt - (AW + 1)'(1);
      end
   end

   // Data storage needs no reset
   always_ff @(posedge i_clk) begin
      if (push) mem[wp] <= i_data;
   end
endmodule // csi_pair_fifo
`default_nettype wire

// file: csi_codec_model.sv
// Behavioural codec model standing on the far side of the serial link
`timescale 1ns/100ps
`default_nettype none
module csi_codec_model (
   // Pin levels seen on the link
   input wire logic i_bclk,
   input wire logic i_fs,
   input wire logic i_dout,
   // Settings from the bench
   input wire logic i_clk_on,
   input wire logic [4:0] i_len,
   input wire logic [15:0] i_word,
   // Codec drive
   output logic o_bclk,
   output logic o_din
);
   logic [15:0] cap_q[$]; // Slot zero words, left justified
   logic idle_q[$]; // Levels heard in unused slots
   logic [15:0] sh = 16'h0000; // Word being gathered
   int cnt = 0; // Bit position within the frame
   bit synced = 1'b0; // Set once a frame end was seen
   initial o_bclk = 1'b0;
   initial o_din = 1'b0;
   // 200 ns bit clock, held low when not asked for
   always begin
      #100;
      o_bclk = i_clk_on ? ~o_bclk : 1'b0;
   end
   // Sample late in the bit, so the device's synchroniser delay never races us
   always @(posedge i_bclk) begin
      #50;
      if (synced && cnt < i_len) sh = {sh[14:0], i_dout};
      if (synced && cnt >= i_len) idle_q.push_back(i_dout);
      if (synced && cnt == i_len - 1) cap_q.push_back(sh << (16 - i_len));
      cnt++;
      // Sync high marks the last bit of a frame
      if (i_fs === 1'b1) begin
         cnt = 0;
         synced = 1'b1;
      end
   end
   // Own slot carries the word MSB first; elsewhere a level that keeps changing
   always @(negedge i_bclk) o_din = (synced && cnt < i_len) ? i_word[15 - cnt] : ~o_din;
endmodule // csi_codec_model
`default_nettype wire

// file: csi_top_test.sv
// Self-checking bench for the codec serial interface
`timescale 1ns/100ps
`default_nettype none
module csi_top_test;
   import csi_pkg::*;
   // Clock, reset and bus drive
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0000_0000;
   logic [31:0] rdat;
   logic ack;
   // Pin outputs, codec drive and bench settings
   csi_pin_type bclk_o, dout_o, fs_o;
   logic codec_clk, codec_din;
   logic clk_on = 1'b0;
   logic slv_fs = 1'b0; // Far-side sync drive while the device listens
   logic [4:0] len = 5'h10;
   logic [15:0] word = 16'h0000;
   // Resolved wire levels; released sync line sits low unless the bench drives it
   wire logic bclk_lvl = bclk_o.oe_n ? codec_clk : bclk_o.drive;
   wire logic fs_lvl = fs_o.oe_n ? slv_fs : fs_o.drive;
   wire logic dout_lvl = dout_o.oe_n ? 1'bz : dout_o.drive;
   // Result counters and model state
   int error_cnt = 0;
   int cmp_count = 0;
   logic [15:0] tx [4];
   logic [31:0] q;
   // 40 MHz clock
   always #12.5 i_clk = ~i_clk;
   csi_top uut (.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
      .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
      .i_serial_bit_clock_pin(bclk_lvl), .i_serial_in_pin(codec_din),
      .i_frame_sync_pin(fs_lvl), .o_serial_bit_clock_pin(bclk_o),
      .o_serial_out_pin(dout_o), .o_frame_sync_pin(fs_o));
   csi_codec_model codec (.i_bclk(bclk_lvl), .i_fs(fs_lvl), .i_dout(dout_lvl),
      .i_clk_on(clk_on), .i_len(len), .i_word(word), .o_bclk(codec_clk), .o_din(codec_din));
   // Verdict and end of run
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // One comparison of a value against the model
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Classic single cycle; held until ack is sampled, read data taken there
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge i_clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge i_clk);
      // No answer at all is a hang
      if (n >= 20) begin
         error_cnt++;
         summarize();
      end
   endtask
   // Poll one status bit, bounded
   task automatic wait_bit(input int b);
      int n;
      n = 0;
      do begin
         wb(1'b0, CSI_OFS_STATUS, 32'h0);
         n++;
      end while (q[b] !== 1'b1 && n < 3000);
      if (n >= 3000) begin
         error_cnt++;
         summarize();
      end
   endtask
   // One enabled run: clock source, idle mode and word length vary
   task automatic run(input logic ext, input logic idle, input logic [3:0] wl);
      logic [15:0] m;
      int n;
      m = 16'hFFFF << (15 - wl);
      codec.synced = 1'b0;
      codec.cap_q.delete();
      codec.idle_q.delete();
      len <= {1'b0, wl} + 5'h01;
      word <= 16'($urandom);
      // Random transmit words, read back while the engine is off
      for (int k = 0; k < 4; k++) begin
         tx[k] = 16'($urandom);
         wb(1'b1, 8'(8'h10 + 4 * k), {16'h0000, tx[k]});
         wb(1'b0, 8'(8'h10 + 4 * k), 32'h0);
         chk(q, {16'h0000, tx[k]});
      end
      clk_on <= ext;
      // Sticky flags from an earlier run would fake the first batch
      wb(1'b1, CSI_OFS_STATUS, 32'h0000_0007);
      wb(1'b1, CSI_OFS_SLOTS, 32'h0000_0001);
      wb(1'b1, CSI_OFS_CTRL2, {24'h000000, 4'h1, wl});
      wb(1'b1, CSI_OFS_CTRL1, {4'h0, ext ? 12'h000 : 12'h003, 12'h000, 1'b0, idle, ext, 1'b1});
      repeat (3) @(posedge i_clk);
      chk(32'(bclk_o.oe_n), 32'(ext));
      chk(32'(fs_o.oe_n), 32'h0);
      // First batch may hold a word from before the codec locked on
      wait_bit(CSI_RXFULL_BIT);
      wb(1'b1, CSI_OFS_STATUS, 32'h0000_0001);
      wait_bit(CSI_RXFULL_BIT);
      for (int k = 0; k < 4; k++) begin
         wb(1'b0, 8'(8'h20 + 4 * k), 32'h0);
         chk(q, {16'h0000, word & m});
      end
      n = 0;
      while (codec.cap_q.size() < 7 && n < 5000) begin
         @(posedge i_clk);
         n++;
      end
      if (n >= 5000) begin
         error_cnt++;
         summarize();
      end
      // Frames four to seven carry the reloaded copy
      for (int k = 0; k < 4; k++) begin
         chk({16'h0000, codec.cap_q[3 + k]}, {16'h0000, tx[k] & m});
      end
      wb(1'b0, CSI_OFS_STATUS, 32'h0);
      chk(32'(q[CSI_TXEMPTY_BIT]), 32'h1);
      chk(32'(codec.idle_q[0]), idle ? 32'h0 : 32'(1'bz));
      // Receiver stalled: buffer fills, then a word is refused
      wait_bit(CSI_OVR_BIT);
      wb(1'b1, CSI_OFS_CTRL1, 32'h0);
      clk_on <= 1'b0;
      repeat (3) @(posedge i_clk);
      chk({29'h0, bclk_o.oe_n, dout_o.oe_n, fs_o.oe_n}, 32'h7);
      wb(1'b0, CSI_OFS_STATUS, 32'h0);
      chk(32'(q[9:4]), 32'h0);
   endtask
   // Main sequence
   initial begin
      void'($urandom(32'hE22FE826));
      repeat (6) @(posedge i_clk);
      i_rst <= 1'b0;
      wb(1'b0, CSI_OFS_CTRL1, 32'h0);
      chk(q, CSI_CTRL1_RST);
      wb(1'b0, CSI_OFS_CTRL2, 32'h0);
      chk(q, CSI_CTRL2_RST);
      wb(1'b0, CSI_OFS_SLOTS, 32'h0);
      chk(q, {16'h0000, CSI_SLOTS_RST});
      // Unmapped place and a read-only receive word
      wb(1'b0, 8'h40, 32'h0);
      chk(q, 32'h0);
      wb(1'b1, 8'h20, 32'h0000_FFFF);
      wb(1'b0, 8'h20, 32'h0);
      chk(q, 32'h0);
      // Every frame mode selectable; pins stay released while off
      for (int m = 0; m < 4; m++) begin
         wb(1'b1, CSI_OFS_CTRL1, {26'h0, 2'(m), 4'h0});
         wb(1'b0, CSI_OFS_CTRL1, 32'h0);
         chk(q, {26'h0, 2'(m), 4'h0});
         chk({29'h0, bclk_o.oe_n, dout_o.oe_n, fs_o.oe_n}, 32'h7);
      end
      run(1'b0, 1'b0, 4'hF);
      run(1'b1, 1'b1, 4'h7);
      // Sync slave on the codec clock: waits, then runs once sync comes
      clk_on <= 1'b1;
      wb(1'b1, CSI_OFS_CTRL1, 32'h0000_000B);
      repeat (40) @(posedge i_clk);
      wb(1'b0, CSI_OFS_STATUS, 32'h0);
      chk(32'(q[9:8]), 32'h1);
      chk(32'(fs_o.oe_n), 32'h1);
      slv_fs <= 1'b1;
      repeat (40) @(posedge i_clk);
      wb(1'b0, CSI_OFS_STATUS, 32'h0);
      chk(32'(q[9:8]), 32'h2);
      summarize();
   end
endmodule // csi_top_test
`default_nettype wire
